// ==== rtl/mad_pkg.sv ====
// Constants and types shared by the multiply-add slice files.
// Assumes one clock domain and an AXI4-Lite register bus of 32 bits.
package mad_pkg;

    // ***
    // Register map and field positions
    // ***
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_GO = 8'h08;
    localparam logic [7:0] OFF_OPA = 8'h10;
    localparam logic [7:0] OFF_OPB = 8'h20;
    localparam logic [7:0] OFF_RES = 8'h30;
    localparam logic [7:0] OFF_END = 8'h50;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CF_FOUR = 0;
    localparam int CF_NARROW = 1;
    localparam int CF_CHAIN = 2;
    localparam int CF_SIGN_A = 3;
    localparam int CF_SIGN_B = 4;
    localparam int CF_SAT = 5;
    localparam int CF_RND = 6;
    localparam int CF_SUB0 = 7;
    localparam int CF_SUB1 = 8;
    localparam int CF_PIPE2 = 9;
    localparam int CF_SGNREG = 10;
    localparam int GO_START = 0;
    localparam int GO_POP = 1;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_DEC = 2'b11;

    // ***
    // Arithmetic sizes
    // ***
    localparam int OPW = 18;
    localparam int PW = 38;
    localparam int LANES = 4;
    localparam int FIFO_D = 8;
    localparam int RND_BIT = 16;
    localparam logic [17:0] Q_MIN = 18'h20000;
    localparam logic [37:0] Q_SAT = 38'h03_ffff_ffff;

    typedef struct packed {
        logic rnd;
        logic sub0;
        logic sub1;
    } mad_ctl_t;

    typedef struct packed {
        logic sign_a;
        logic sign_b;
        logic sat_en;
    } mad_sgn_t;

    typedef struct packed {
        logic [3:0] sat;
        logic [3:0][PW-1:0] sum;
    } mad_res_t;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_AW = 2'b01,
        WS_W = 2'b10,
        WS_RESP = 2'b11
    } mad_wst_t;

endpackage

// ==== rtl/mad_fifo.sv ====
// Result FIFO with valid and ready on both sides.
// Assumes the reader pops only while out_valid is high.
`timescale 1ns/1ps
module mad_fifo
    import mad_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest full and empty flags drive both handshakes.
    assign in_ready = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count updates.
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; out_data shows mem_r[rp_r] even while the FIFO is empty.
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

// ==== rtl/mad_mult.sv ====
// One multiplier lane: one 18x18 product or two 9x9 products.
// Assumes operands are held stable by the caller's input registers.
`timescale 1ns/1ps
module mad_mult
    import mad_pkg::*;
(
    input wire logic [OPW-1:0] a,
    input wire logic [OPW-1:0] b,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic narrow,
    input wire logic rnd,
    input wire logic sat_en,
    output logic [PW-1:0] prod_lo,
    output logic [PW-1:0] prod_hi,
    output logic sat
);
    // Signed 9x9 product, sign chosen per operand, widened to PW.
    function automatic logic [PW-1:0] mul9(input logic [8:0] x,
        input logic [8:0] y, input logic sx, input logic sy);
        logic signed [19:0] p;
        p = $signed({sx & x[8], x}) * $signed({sy & y[8], y});
        return PW'(p);
    endfunction

    logic signed [PW-1:0] wide;
    logic q_mode;

    // Q1.15 rounding and saturation only for signed full-width use.
    always_comb begin
        wide = $signed({sign_a & a[17], a}) * $signed({sign_b & b[17], b});
        q_mode = !narrow && sign_a && sign_b && sat_en;
        sat = q_mode && (a == Q_MIN) && (b == Q_MIN);
        if (sat) begin
            wide = Q_SAT;
        end else if (q_mode && rnd) begin
            wide = wide + (PW'(1) << RND_BIT);
            wide[RND_BIT:0] = '0;
        end
        if (narrow) begin
            prod_lo = mul9(a[8:0], b[8:0], sign_a, sign_b);
            prod_hi = mul9(a[17:9], b[17:9], sign_a, sign_b);
        end else begin
            prod_lo = wide;
            prod_hi = '0;
        end
    end
endmodule

// ==== rtl/mad_slice.sv ====
// Multiply-add slice with AXI4-Lite registers and a result FIFO.
// Assumes one clock, synchronous active-low reset, inputs synchronous.
// Summary of operation
// RQ1 - Adder sums two or four products by mode.
// RQ2 - Adder inputs are multiplier products only.
// RQ3 - Two-product mode: four 9-bit or two 18-bit adders.
// RQ4 - Each pair adder adds or subtracts at run time.
// RQ5 - Round and subtract controls pass one or two stages.
// RQ6 - Sign and saturate controls are live or registered once.
// RQ7 - Saturation flags share the data path latency.
// RQ8 - 18-bit complex: real by subtractor, imaginary by adder.
// RQ9 - 9-bit data: two complex products, eight small multipliers.
// RQ10 - Outside logic routes real and imaginary parts to inputs.
// RQ11 - Four-product mode: one 18-bit or two 9-bit adders.
// RQ12 - Four products summed in two stages.
// RQ13 - Round and saturate only for signed 18x18 Q1.15 inputs.
// RQ14 - Input B registers can shift along the dedicated chain.
// RQ15 - Outside logic puts samples on chain, coefficients on A.
// RQ16 - No 36-bit mode, so chain never serves that mode.
// RQ17 - One slice gives a four-tap 18-bit filter; cascade beyond.
// RQ18 - Signedness chosen per operand, changeable at run time.
// RQ19 - Register groups clear to zero on reset.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mad_slice
    import mad_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [OPW-1:0] chain_in_b,
    output logic [OPW-1:0] chain_out_b,
    output logic product0_saturated_flag,
    output logic product1_saturated_flag
);
    // ***
    // Helpers
    // ***

    // Merges a write word into a register under byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Adds or subtracts two products.
    function automatic logic [PW-1:0] addsub(input logic [PW-1:0] x,
        input logic [PW-1:0] y, input logic sub);
        return sub ? x - y : x + y;
    endfunction

    // ***
    // Declarations
    // ***
    mad_wst_t wst_r, wst_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt, wr_addr, ra;
    logic [31:0] wdata_r, wdata_nxt, wr_data;
    logic [3:0] wstrb_r, wstrb_nxt, wr_strb;
    logic [1:0] bresp_r, bresp_nxt, wr_resp;
    logic wr_do, wr_hit;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt, rd_word;
    logic [1:0] rresp_r, rresp_nxt, rd_resp;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [3:0][OPW-1:0] opa_r, opa_nxt, opb_r, opb_nxt;
    logic [3:0][OPW-1:0] ina_r, ina_nxt, inb_r, inb_nxt;
    mad_sgn_t sgn_r, sgn_nxt, sgn_live, sgn_use;
    mad_ctl_t ctl1_r, ctl2_r, ctl_use;
    logic v0_r, v0_nxt, v1_r, v1_nxt, go, pop;
    logic [3:0][PW-1:0] plo, phi, plo_r, phi_r;
    logic [3:0] psat, psat_r;
    logic [PW-1:0] f0, f1, f2, f3;
    mad_res_t res_in, res_out;
    logic fifo_in_ready, fifo_out_valid;
    logic [3:0] fifo_level;
    logic [1:0] flag_r, flag_nxt;

    // ***
    // AXI4-Lite write channel
    // ***

    // Address and data are taken in either order, answer after both.
    assign s_axi_awready = (wst_r == WS_IDLE) || (wst_r == WS_W);
    assign s_axi_wready = (wst_r == WS_IDLE) || (wst_r == WS_AW);
    assign s_axi_bvalid = (wst_r == WS_RESP);
    assign s_axi_bresp = bresp_r;
    assign wr_addr = (wst_r == WS_AW) ? awaddr_r : s_axi_awaddr;
    assign wr_data = (wst_r == WS_W) ? wdata_r : s_axi_wdata;
    assign wr_strb = (wst_r == WS_W) ? wstrb_r : s_axi_wstrb;

    always_comb begin
        wst_nxt = wst_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        wr_do = 1'b0;
        case (wst_r)
            WS_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    wr_do = 1'b1;
                    wst_nxt = WS_RESP;
                end else if (s_axi_awvalid) begin
                    awaddr_nxt = s_axi_awaddr;
                    wst_nxt = WS_AW;
                end else if (s_axi_wvalid) begin
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                    wst_nxt = WS_W;
                end
            end
            WS_AW: begin
                if (s_axi_wvalid) begin
                    wr_do = 1'b1;
                    wst_nxt = WS_RESP;
                end
            end
            WS_W: begin
                if (s_axi_awvalid) begin
                    wr_do = 1'b1;
                    wst_nxt = WS_RESP;
                end
            end
            WS_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = WS_IDLE;
                end
            end
            default: wst_nxt = WS_IDLE;
        endcase
        bresp_nxt = wr_do ? wr_resp : bresp_r;
    end

    // Register decode of a write; GO and POP act only as pulses.
    always_comb begin
        ctrl_nxt = ctrl_r;
        opa_nxt = opa_r;
        opb_nxt = opb_r;
        go = 1'b0;
        pop = 1'b0;
        wr_hit = 1'b1;
        if (!wr_do) begin
            wr_hit = 1'b1;
        end else if (wr_addr == OFF_CTRL) begin
            ctrl_nxt = merge(ctrl_r, wr_data, wr_strb);
        end else if (wr_addr == OFF_GO) begin
            go = wr_strb[0] && wr_data[GO_START];
            pop = wr_strb[0] && wr_data[GO_POP] && fifo_out_valid;
        end else if (wr_addr >= OFF_OPA && wr_addr < OFF_OPB &&
                     wr_addr[1:0] == 2'b00) begin
            opa_nxt[wr_addr[3:2]] = OPW'(merge(32'(opa_r[wr_addr[3:2]]),
                wr_data, wr_strb));
        end else if (wr_addr >= OFF_OPB && wr_addr < OFF_RES &&
                     wr_addr[1:0] == 2'b00) begin
            opb_nxt[wr_addr[3:2]] = OPW'(merge(32'(opb_r[wr_addr[3:2]]),
                wr_data, wr_strb));
        end else if (wr_addr == OFF_STATUS || (wr_addr >= OFF_RES &&
                     wr_addr < OFF_END && wr_addr[1:0] == 2'b00)) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
        wr_resp = wr_hit ? RESP_OK : RESP_DEC;
    end

    // RQ19 cleared on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r <= WS_IDLE;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bresp_r <= RESP_OK;
            ctrl_r <= CTRL_RST;
            opa_r <= '0;
            opb_r <= '0;
        end else begin
            wst_r <= wst_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
            ctrl_r <= ctrl_nxt;
            opa_r <= opa_nxt;
            opb_r <= opb_nxt;
        end
    end

    // ***
    // AXI4-Lite read channel
    // ***
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign ra = s_axi_araddr;

    // Read decode; result words show the FIFO head without popping.
    always_comb begin
        logic [PW-1:0] s;
        s = res_out.sum[ra[4:3] - 2'd2];
        rd_word = '0;
        rd_resp = RESP_OK;
        if (ra == OFF_CTRL) begin
            rd_word = ctrl_r;
        end else if (ra == OFF_STATUS) begin
            rd_word = {21'h000000, fifo_out_valid ? res_out.sat : 4'h0,
                fifo_level, fifo_out_valid, fifo_in_ready, v0_r | v1_r};
        end else if (ra == OFF_GO) begin
            rd_word = '0;
        end else if (ra >= OFF_OPA &&
                     ra < OFF_OPB &&
                     ra[1:0] == 2'b00) begin
            rd_word = 32'(opa_r[ra[3:2]]);
        end else if (ra >= OFF_OPB &&
                     ra < OFF_RES &&
                     ra[1:0] == 2'b00) begin
            rd_word = 32'(opb_r[ra[3:2]]);
        end else if (ra >= OFF_RES &&
                     ra < OFF_END &&
                     ra[1:0] == 2'b00) begin
            if (ra[2]) begin
                rd_word = {{26{s[PW-1]}}, s[PW-1:32]};
            end else begin
                rd_word = s[31:0];
            end
        end else begin
            rd_resp = RESP_DEC;
        end
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_word;
            rresp_nxt = rd_resp;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OK;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ***
    // Input registers and control pipeline
    // ***
    assign sgn_live = '{sign_a: ctrl_r[CF_SIGN_A],
        sign_b: ctrl_r[CF_SIGN_B], sat_en: ctrl_r[CF_SAT]};
    // RQ6 live or once
    assign sgn_use = ctrl_r[CF_SGNREG] ? sgn_r : sgn_live;
    // RQ5 one or two
    assign ctl_use = ctrl_r[CF_PIPE2] ? ctl2_r : ctl1_r;
    assign chain_out_b = inb_r[3];

    // A start is taken only with the pipeline empty and FIFO room.
    always_comb begin
        ina_nxt = ina_r;
        inb_nxt = inb_r;
        sgn_nxt = sgn_r;
        v0_nxt = 1'b0;
        if (go && !v0_r && !v1_r && fifo_in_ready) begin
            v0_nxt = 1'b1;
            // RQ18 per-operand sign
            sgn_nxt = sgn_live;
            ina_nxt = opa_r;
            // RQ14 shift chain
            // RQ16 four-product only
            if (ctrl_r[CF_CHAIN] && ctrl_r[CF_FOUR]) begin
                // RQ15 samples on chain
                inb_nxt = {inb_r[2:0], chain_in_b};
            end else begin
                inb_nxt = opb_r;
            end
        end
    end

    // RQ19 cleared on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ina_r <= '0;
            inb_r <= '0;
            sgn_r <= '0;
            v0_r <= 1'b0;
            ctl1_r <= '0;
            ctl2_r <= '0;
        end else begin
            ina_r <= ina_nxt;
            inb_r <= inb_nxt;
            sgn_r <= sgn_nxt;
            v0_r <= v0_nxt;
            ctl1_r <= '{rnd: ctrl_r[CF_RND], sub0: ctrl_r[CF_SUB0],
                sub1: ctrl_r[CF_SUB1]};
            ctl2_r <= ctl1_r;
        end
    end

    // ***
    // Multiplier stage
    // ***

    // RQ13 Q1.15 gating
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        mad_mult u_mult (
            .a(ina_r[i]),
            .b(inb_r[i]),
            .sign_a(sgn_use.sign_a),
            .sign_b(sgn_use.sign_b),
            .narrow(ctrl_r[CF_NARROW]),
            .rnd(ctl_use.rnd),
            .sat_en(sgn_use.sat_en),
            .prod_lo(plo[i]),
            .prod_hi(phi[i]),
            .sat(psat[i])
        );
    end

    // Products and their flags are registered together.
    always_comb begin
        v1_nxt = v0_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            v1_r <= 1'b0;
            plo_r <= '0;
            phi_r <= '0;
            psat_r <= '0;
        end else begin
            v1_r <= v1_nxt;
            plo_r <= plo;
            phi_r <= phi;
            psat_r <= psat;
        end
    end

    // ***
    // Adder and summation stage
    // ***

    // RQ2 products only
    // RQ4 run-time add/subtract
    always_comb begin
        f0 = addsub(plo_r[0], plo_r[1], ctl_use.sub0);
        f1 = addsub(phi_r[0], phi_r[1], ctl_use.sub0);
        f2 = addsub(plo_r[2], plo_r[3], ctl_use.sub1);
        f3 = addsub(phi_r[2], phi_r[3], ctl_use.sub1);
        res_in.sat = psat_r;
        res_in.sum = '0;
        // RQ1 two or four
        if (!ctrl_r[CF_FOUR]) begin
            // RQ3 two-product adders
            // RQ8 complex real and imaginary
            // RQ9 two small complex
            res_in.sum[0] = f0;
            res_in.sum[1] = ctrl_r[CF_NARROW] ? f1 : f2;
            res_in.sum[2] = ctrl_r[CF_NARROW] ? f2 : '0;
            res_in.sum[3] = ctrl_r[CF_NARROW] ? f3 : '0;
        end else begin
            // RQ11 four-product adders
            // RQ12 second stage sum
            // RQ17 four taps
            res_in.sum[0] = f0 + f2;
            res_in.sum[1] = ctrl_r[CF_NARROW] ? f1 + f3 : '0;
        end
    end

    // RQ7 flags match data
    always_comb begin
        flag_nxt = v1_r ? psat_r[1:0] : flag_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign product0_saturated_flag = flag_r[0];
    assign product1_saturated_flag = flag_r[1];

    // ***
    // Result buffering
    // ***

    // A full FIFO refuses new starts, so the push never finds it full.
    mad_fifo #(
        .W($bits(mad_res_t)),
        .D(FIFO_D)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(v1_r),
        .in_ready(fifo_in_ready),
        .in_data(res_in),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(res_out),
        .level(fifo_level)
    );
endmodule

// ==== tb/mad_prev_slice.sv ====
// Model of the preceding slice on the B sample shift chain.
// Assumes the bench sets the next sample well before each start.
`timescale 1ns/1ps
module mad_prev_slice
    import mad_pkg::*;
(
    input wire logic aclk,
    input wire logic [OPW-1:0] next_sample,
    output logic [OPW-1:0] chain_out
);
    // samples on chain
    // Registers each sample as the last B stage of a slice would.
    always_ff @(posedge aclk) begin
        chain_out <= next_sample;
    end
endmodule

// ==== tb/mad_slice_monitor.sv ====
// Checker of the slice's handshakes, chain and flag timing.
// Assumes it is bound to mad_slice and sees only its ports.
`timescale 1ns/1ps
module mad_slice_monitor
    import mad_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [OPW-1:0] chain_out_b,
    input wire logic product0_saturated_flag,
    input wire logic product1_saturated_flag
);
    // ***
    // Properties
    // ***
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped early");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid stuck");
    AST_NO_AW: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read not answered");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid [*1]) else $error("rvalid dropped early");
    AST_FLAG0: assert property ($changed(product0_saturated_flag) |->
        $past(s_axi_bvalid, 2)) else $error("flag0 off latency");
    AST_FLAG1: assert property ($changed(product1_saturated_flag) |->
        $past(s_axi_bvalid, 2)) else $error("flag1 off latency");
    AST_CHAIN: assert property ($changed(chain_out_b) |->
        s_axi_bvalid) else $error("chain moved without start");
    AST_RST: assert property (disable iff (1'b0) !aresetn |=>
        chain_out_b == '0 && !product0_saturated_flag)
        else $error("reset did not clear");
    // Main scenarios reached.
    cover property ($rose(product0_saturated_flag));
    cover property ($changed(chain_out_b));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind mad_slice mad_slice_monitor MON (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .chain_out_b,
    .product0_saturated_flag, .product1_saturated_flag);

// ==== tb/tb.sv ====
// Self-checking bench of the multiply-add slice.
// Assumes all design files are compiled first.
`timescale 1ns/1ps
module tb
    import mad_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [OPW-1:0] sample = 18'h0, chain_in_b, chain_out_b;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, product0_saturated_flag, product1_saturated_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [37:0] p[4], l[4], h[4];
    logic [17:0] oa[4], ob[4];
    int bad_count = 0;
    int check_count = 0;
    // Clock of 5 ns.
    always #2.5 aclk = ~aclk;
    mad_prev_slice PREV (.aclk, .next_sample(sample), .chain_out(chain_in_b));
    mad_slice DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chain_in_b, .chain_out_b, .product0_saturated_flag,
        .product1_saturated_flag);
    // ***
    // Bus tasks and checks
    // ***
    task automatic end_sim();
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [37:0] g, e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Channels move at the rising edge where valid meets ready.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        bad_count++;
        end_sim();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        bad_count++;
        end_sim();
    endtask
    task automatic rres(input int k, input logic [37:0] e);
        logic [31:0] lo, hi;
        rd(OFF_RES + 8'(8 * k), lo);
        rd(OFF_RES + 8'(8 * k + 4), hi);
        chk("result", {hi[5:0], lo}, e);
    endtask
    // Sets controls, starts, reads all slots, pops.
    task automatic run(input logic [31:0] c, input logic [37:0] e0, e1, e2, e3);
        logic [37:0] e[4];
        e = '{e0, e1, e2, e3};
        wr(OFF_CTRL, c);
        repeat (4) @(posedge aclk);
        wr(OFF_GO, 32'h1);
        repeat (4) @(posedge aclk);
        for (int k = 0; k < 4; k++) rres(k, e[k]);
        wr(OFF_GO, 32'h2);
    endtask
    // ***
    // Main sequence
    // ***
    initial begin
        logic [31:0] v;
        oa = '{18'h603, 18'h2, 18'h4, 18'h205};
        ob = '{18'h405, 18'h7, 18'h6, 18'h2};
        for (int i = 0; i < 4; i++) begin
            p[i] = 38'(oa[i]) * ob[i];
            l[i] = 38'(oa[i][8:0]) * ob[i][8:0];
            h[i] = 38'(oa[i][17:9]) * ob[i][17:9];
        end
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CTRL, v);
        chk("ctrl", v, CTRL_RST);
        rd(OFF_STATUS, v);
        chk("status", v, 32'h2);
        rd(8'h54, v);
        chk("rd unmapped", {v, resp}, {32'h0, RESP_DEC});
        wr(8'h60, 32'h1);
        chk("wr unmapped", resp, RESP_DEC);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_OPA + 8'(4 * i), 32'(oa[i]));
            wr(OFF_OPB + 8'(4 * i), 32'(ob[i]));
        end
        run(32'h0, p[0] + p[1], p[2] + p[3], '0, '0);
        run(32'h180, p[0] - p[1], p[2] - p[3], '0, '0);
        run(32'h380, p[0] - p[1], p[2] - p[3], '0, '0);
        run(32'h2, l[0] + l[1], h[0] + h[1], l[2] + l[3], h[2] + h[3]);
        run(32'h82, l[0] - l[1], h[0] - h[1], l[2] + l[3], h[2] + h[3]);
        run(32'h101, p[0] + p[1] + p[2] - p[3], '0, '0, '0);
        run(32'h3, l[0] + l[1] + l[2] + l[3], h[0] + h[1] + h[2] + h[3],
            '0, '0);
        wr(OFF_OPA, 32'h20000);
        wr(OFF_OPB, 32'h20000);
        wr(OFF_OPA + 8'h4, 32'h0);
        run(32'h38, 38'h3ffffffff, p[2] + p[3], '0, '0);
        chk("sat0", product0_saturated_flag, 1'b1);
        chk("sat1", product1_saturated_flag, 1'b0);
        run(32'h3a, '0, 38'h10000, l[2] + l[3], h[2] + h[3]);
        chk("sat0 narrow", product0_saturated_flag, 1'b0);
        wr(OFF_OPA + 8'h4, 32'h3ffff);
        run(32'h18, 38'h3fffffff9, p[2] + p[3], '0, '0);
        run(32'h418, 38'h3fffffff9, p[2] + p[3], '0, '0);
        run(32'h78, 38'h3ffffffff, '0, '0, '0);
        run(32'h0, 38'h4001bfff9, p[2] + p[3], '0, '0);
        // Chain starts without popping until the FIFO refuses.
        wr(OFF_CTRL, 32'h5);
        for (int i = 0; i < 9; i++) begin
            sample <= 18'(i + 1);
            repeat (4) @(posedge aclk);
            wr(OFF_GO, 32'h1);
            repeat (4) @(posedge aclk);
            if (i == 3) chk("chain", chain_out_b, 18'h1);
        end
        rd(OFF_STATUS, v);
        chk("full", v, 32'h44);
        for (int i = 0; i < 8; i++) begin
            if (i == 3) rres(0, 38'h80000 + 38'hbfffd + 38'h8 + 38'h205);
            wr(OFF_GO, 32'h2);
        end
        rd(OFF_STATUS, v);
        chk("empty", v, 32'h2);
        end_sim();
    end
endmodule
